// ===== hdl/srstc_pkg.sv
// Shared constants, register map and types of the system reset controller.
// Assumes a single 25 MHz clock and a 32-bit AXI4-Lite register bus.
package srstc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 3;

  // Printed register indexes; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CAUSE  = 3'h0;
  localparam logic [IDX_W-1:0] IDX_SOFT_RST = 3'h1;
  localparam logic [IDX_W-1:0] IDX_UNLOCK = 3'h2;
  localparam logic [IDX_W-1:0] IDX_STATUS = 3'h3;

  localparam int FLAGS_W = 6;
  localparam int FLAG_POR = 0;
  localparam int FLAG_BOD = 1;
  localparam int FLAG_PIN = 2;
  localparam int FLAG_WDT = 3;
  localparam int FLAG_SW = 4;
  localparam int FLAG_DBG = 5;
  localparam logic [FLAGS_W-1:0] FLAGS_POR_ONLY = 6'h01;
  localparam logic [FLAGS_W-1:0] FLAGS_NONE = 6'h00;

  localparam int SYNC_W = 5;
  localparam int SYN_POR = 0;
  localparam int SYN_BOD = 1;
  localparam int SYN_PIN_N = 2;
  localparam int SYN_WDT = 3;
  localparam int SYN_DBG = 4;

  localparam int SOFT_TRIGGER_BIT = 0;
  localparam int STRB_LOW = 0;
  localparam int KEY_W = 8;
  // Unlock key value is arbitrary.
  localparam logic [KEY_W-1:0] UNLOCK_KEY = 8'hA5;
  localparam int WIN_W = 3;
  localparam logic [WIN_W-1:0] UNLOCK_WINDOW = 3'h4;
  localparam logic [WIN_W-1:0] WIN_CLOSED = 3'h0;

  localparam int SUT_W = 3;
  localparam logic [SUT_W-1:0] FUSE_SUT_RST = 3'h0;
  localparam logic FUSE_CRC_RST = 1'b0;
  localparam logic FUSE_PIN_EN_RST = 1'b1;

  localparam int CLK_PERIOD_NS = 40;
  localparam int INIT_TIME_NS = 200;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUT_UNIT_NS = 1000;
  localparam int SUT_UNIT_CYCLES = SUT_UNIT_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 12;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_FUSE,
    ST_INIT,
    ST_CRC,
    ST_RUN
  } srstc_state_t;

  // Start-up delay: zero extra for code 0, else 2**(code-1) microseconds.
  function automatic logic [TIMER_W-1:0] sut_cycles(input logic [SUT_W-1:0] startup_delay_select);
    int extra;
    extra = (startup_delay_select == FUSE_SUT_RST) ? 0 : ((1 << (startup_delay_select - 1)) * SUT_UNIT_CYCLES);
    sut_cycles = TIMER_W'(extra + INIT_CYCLES);
  endfunction

endpackage

// ===== hdl/srstc_sync.sv
// Two-flop synchroniser for the asynchronous reset request inputs.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ps
module srstc_sync
  import srstc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [SYNC_W-1:0] async_in,
  input  wire logic [SYNC_W-1:0] reset_value,
  output logic      [SYNC_W-1:0] sync_out
);

  logic [SYNC_W-1:0] stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1   <= {SYNC_W{1'b0}};
      sync_out <= {SYNC_W{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

  logic unused_rv;
  assign unused_rv = ^reset_value;

endmodule

// ===== hdl/srstc_timer.sv
// Down-counter timing the internal initialisation after reset release.
// Assumes load is a single-cycle strobe from the sequencer.
`timescale 1ns/1ps
module srstc_timer
  import srstc_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               load,
  input  wire logic [TIMER_W-1:0] load_value,
  output logic                    expired
);

  logic [TIMER_W-1:0] count;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= {TIMER_W{1'b0}};
    end else if (load) begin
      count <= load_value;
    end else if (count != {TIMER_W{1'b0}}) begin
      count <= count - TIMER_W'(1);
    end
  end

  assign expired = (count == {TIMER_W{1'b0}}) && !load;

endmodule

// ===== hdl/srstc_top.sv
// System reset controller: merges reset requests, sequences release, logs cause.
// Assumes request inputs are asynchronous and the fuse loader and CRC scanner
// share clk. The AXI4-Lite slave keeps running while the system is held in reset.
`timescale 1ns/1ps
module srstc_top
  import srstc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              por_req,
  input  wire logic              bod_req,
  input  wire logic              pin_reset_n,
  input  wire logic              wdt_req,
  input  wire logic              dbg_req,
  output logic                   fuse_load_req,
  input  wire logic              fuse_load_done,
  input  wire logic [SUT_W-1:0]  fuse_sut,
  input  wire logic              fuse_crc_at_boot,
  input  wire logic              fuse_reset_pin_en,
  output logic                   crc_scan_start,
  input  wire logic              crc_scan_done,
  output logic                   sys_reset_n,
  output logic                   rst_volatile_n,
  output logic                   rst_tcd_override_n,
  output logic                   rst_bod_cfg_n,
  output logic                   rst_debug_n,
  output logic                   tcd_override_avail,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  srstc_state_t        state;
  srstc_state_t        next_state;
  logic [SYNC_W-1:0]   req_sync;
  logic [FLAGS_W-1:0]  cause_flags;
  logic [FLAGS_W-1:0]  next_cause_flags;
  logic [FLAGS_W-1:0]  set_vec;
  logic [FLAGS_W-1:0]  clear_vec;
  logic                por_lock;
  logic                por_cause;
  logic                bod_cause;
  logic                sw_pulse;
  logic                req_any;
  logic [SUT_W-1:0]    fuse_sut_q;
  logic                fuse_crc_q;
  logic                fuse_pin_en_q;
  logic                timer_load;
  logic                timer_expired;
  logic [WIN_W-1:0]    unlock_left;
  logic                aw_held;
  logic                w_held;
  logic [ADDR_W-1:0]   aw_addr;
  logic [DATA_W-1:0]   w_data;
  logic                w_low_lane;
  logic                do_write;
  logic                rd_take;
  logic [IDX_W-1:0]    wr_idx;
  logic                soft_rst_write;
  logic                key_write;

  function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic index_mapped(input logic [ADDR_W-1:0] addr);
    index_mapped = (reg_index(addr) <= IDX_STATUS) && (addr[IDX_LSB-1:0] == 2'h0);
  endfunction

  // free-running logic
  // Nothing here is gated by sleep; the block runs on clk in every mode.
  srstc_sync u_sync (
    .clk         (clk),
    .reset_n     (reset_n),
    .async_in    ({dbg_req, wdt_req, pin_reset_n, bod_req, por_req}),
    .reset_value ({SYNC_W{1'b0}}),
    .sync_out    (req_sync)
  );

  always_comb begin
    set_vec            = FLAGS_NONE;
    set_vec[FLAG_POR]  = req_sync[SYN_POR];
    set_vec[FLAG_BOD]  = req_sync[SYN_BOD];
    set_vec[FLAG_PIN]  = !req_sync[SYN_PIN_N] && fuse_pin_en_q;
    set_vec[FLAG_WDT]  = req_sync[SYN_WDT];
    set_vec[FLAG_SW]   = sw_pulse;
    set_vec[FLAG_DBG]  = req_sync[SYN_DBG];
    req_any            = |set_vec;
  end

  srstc_timer u_timer (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (timer_load),
    .load_value (sut_cycles(fuse_sut)),
    .expired    (timer_expired)
  );

  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    if (req_any) begin
      next_state = ST_HOLD;
    end else begin
      unique case (state)
        ST_HOLD: next_state = ST_FUSE;
        ST_FUSE: begin
          if (fuse_load_done) begin
            next_state = ST_INIT;
            timer_load = 1'b1;
          end
        end
        ST_INIT: begin
          if (timer_expired) begin
            next_state = fuse_crc_q ? ST_CRC : ST_RUN;
          end
        end
        ST_CRC: begin
          if (crc_scan_done) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: next_state = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // fuse reload
  // Fuse copies are refreshed on every pass through the sequence.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fuse_sut_q    <= FUSE_SUT_RST;
      fuse_crc_q    <= FUSE_CRC_RST;
      fuse_pin_en_q <= FUSE_PIN_EN_RST;
    end else if (state == ST_FUSE && fuse_load_done) begin
      fuse_sut_q    <= fuse_sut;
      fuse_crc_q    <= fuse_crc_at_boot;
      fuse_pin_en_q <= fuse_reset_pin_en;
    end
  end

  // Kind of the running reset, kept until the system is released.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      por_cause <= 1'b1;
      bod_cause <= 1'b0;
    end else if (req_sync[SYN_POR] || req_sync[SYN_BOD]) begin
      por_cause <= por_cause || req_sync[SYN_POR];
      bod_cause <= bod_cause || req_sync[SYN_BOD];
    end else if (state == ST_RUN) begin
      por_cause <= 1'b0;
      bod_cause <= 1'b0;
    end
  end

  // domain selection
  // Reset outputs follow the sequencer one cycle later, so release is glitch free.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sys_reset_n        <= 1'b0;
      rst_volatile_n     <= 1'b0;
      rst_tcd_override_n <= 1'b0;
      rst_bod_cfg_n      <= 1'b0;
      rst_debug_n        <= 1'b0;
      tcd_override_avail <= 1'b0;
      fuse_load_req      <= 1'b0;
      crc_scan_start     <= 1'b0;
    end else begin
      sys_reset_n        <= (state == ST_RUN) && !req_any;
      rst_volatile_n     <= (state == ST_RUN) && !req_any;
      rst_tcd_override_n <= !(por_cause && state != ST_RUN);
      rst_bod_cfg_n      <= !(por_cause && state != ST_RUN);
      rst_debug_n        <= !((por_cause || bod_cause) && state != ST_RUN);
      tcd_override_avail <= !(por_cause && state != ST_RUN);
      fuse_load_req      <= (next_state == ST_FUSE);
      crc_scan_start     <= (next_state == ST_CRC);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      por_lock <= 1'b1;
    end else if (req_sync[SYN_POR]) begin
      por_lock <= 1'b1;
    end else if (state == ST_RUN) begin
      por_lock <= 1'b0;
    end
  end

  // AXI write channels are accepted independently and joined here.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx        = reg_index(aw_addr);
  assign soft_rst_write = do_write && index_mapped(aw_addr) && (wr_idx == IDX_SOFT_RST)
                         && w_low_lane;
  assign key_write     = do_write && index_mapped(aw_addr) && (wr_idx == IDX_UNLOCK)
                         && w_low_lane && (w_data[KEY_W-1:0] == UNLOCK_KEY);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      w_held     <= 1'b0;
      w_data     <= {DATA_W{1'b0}};
      w_low_lane <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held     <= 1'b1;
      w_data     <= s_axi_wdata;
      w_low_lane <= s_axi_wstrb[STRB_LOW];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= index_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unlock window
  // The window counts bus accesses, the nearest stand-in for instructions.
  assign rd_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      unlock_left <= WIN_CLOSED;
    end else if (key_write) begin
      unlock_left <= UNLOCK_WINDOW;
    end else if (soft_rst_write || state != ST_RUN) begin
      unlock_left <= WIN_CLOSED;
    end else if ((do_write || rd_take) && unlock_left != WIN_CLOSED) begin
      unlock_left <= unlock_left - WIN_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sw_pulse <= 1'b0;
    end else begin
      sw_pulse <= soft_rst_write && (unlock_left != WIN_CLOSED)
                  && w_data[SOFT_TRIGGER_BIT];
    end
  end

  always_comb begin
    clear_vec = FLAGS_NONE;
    if (do_write && index_mapped(aw_addr) && wr_idx == IDX_CAUSE && w_low_lane) begin
      clear_vec = w_data[FLAGS_W-1:0];
    end
  end

  // flag layout
  // Set wins over a clear landing in the same cycle.
  always_comb begin
    if (req_sync[SYN_POR]) begin
      next_cause_flags = FLAGS_POR_ONLY;
    end else if (por_lock) begin
      next_cause_flags = cause_flags & ~(clear_vec & FLAGS_POR_ONLY);
    end else begin
      next_cause_flags = (cause_flags & ~clear_vec) | set_vec;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cause_flags <= FLAGS_POR_ONLY;
    end else begin
      cause_flags <= next_cause_flags;
    end
  end

  // AXI read: one outstanding read, answered the cycle after it is taken.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= {DATA_W{1'b0}};
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= index_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata  <= {DATA_W{1'b0}};
      if (index_mapped(s_axi_araddr)) begin
        unique case (reg_index(s_axi_araddr))
          IDX_CAUSE:  s_axi_rdata <= DATA_W'(cause_flags);
          IDX_SOFT_RST: s_axi_rdata <= {DATA_W{1'b0}};
          IDX_UNLOCK: s_axi_rdata <= DATA_W'(unlock_left != WIN_CLOSED);
          IDX_STATUS: s_axi_rdata <= DATA_W'({fuse_pin_en_q, fuse_crc_q, fuse_sut_q,
                                               unlock_left != WIN_CLOSED, state});
          default:    s_axi_rdata <= {DATA_W{1'b0}};
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  logic unused_bits;
  assign unused_bits = ^{s_axi_wstrb[3:1], w_data[DATA_W-1:KEY_W]};

endmodule

// ===== tb/srstc_checker.sv
// Concurrent checks on the ports of the reset controller top module.
// Assumes one clock domain and a bench that holds each request for several cycles.
`timescale 1ns/1ps
module srstc_checker
  import srstc_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              por_req,
  input wire logic              bod_req,
  input wire logic              pin_reset_n,
  input wire logic              wdt_req,
  input wire logic              dbg_req,
  input wire logic              fuse_load_req,
  input wire logic              crc_scan_start,
  input wire logic              sys_reset_n,
  input wire logic              rst_volatile_n,
  input wire logic              rst_tcd_override_n,
  input wire logic              rst_bod_cfg_n,
  input wire logic              rst_debug_n,
  input wire logic              tcd_override_avail,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_rvalid,
  input wire logic [DATA_W-1:0] s_axi_rdata
);
  logic any_req;

  assign any_req = por_req || bod_req || wdt_req || dbg_req || !pin_reset_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_init_start;
    $fell(fuse_load_req);
  endsequence

  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // Six cycles cover the two synchroniser flops and the output register.
  a_req_reset: assert property (any_req [*6] |-> !sys_reset_n)
    else $error("request did not hold the system in reset");
  a_release_quiet: assert property ($rose(sys_reset_n) |-> !fuse_load_req && !crc_scan_start)
    else $error("reset released before its sequence ended");
  a_load_in_reset: assert property (fuse_load_req || crc_scan_start |-> !sys_reset_n)
    else $error("fuse load or scan while system runs");
  a_init_min: assert property (s_init_start |-> !sys_reset_n [*5])
    else $error("initialisation shorter than five cycles");
  a_init_bound: assert property (s_init_start |-> ##[5:1000] (sys_reset_n || fuse_load_req))
    else $error("initialisation never ended");
  a_domains_tied: assert property (rst_volatile_n == sys_reset_n && rst_bod_cfg_n == rst_tcd_override_n
                                   && tcd_override_avail == rst_tcd_override_n)
    else $error("reset domain outputs disagree");
  a_por_scope: assert property (!rst_tcd_override_n |-> !rst_debug_n && !sys_reset_n)
    else $error("power-on domain reset outside a full reset");
  a_debug_scope: assert property (!rst_debug_n |-> !sys_reset_n)
    else $error("debug port reset outside a system reset");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_trigger_zero: assert property (s_rd_taken and (s_axi_araddr == 8'h04) |=> !s_axi_rdata[0])
    else $error("trigger bit read back as one");
endmodule

bind srstc_top srstc_checker chk (.clk, .reset_n, .por_req, .bod_req, .pin_reset_n, .wdt_req,
  .dbg_req, .fuse_load_req, .crc_scan_start, .sys_reset_n, .rst_volatile_n, .rst_tcd_override_n,
  .rst_bod_cfg_n, .rst_debug_n, .tcd_override_avail, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata);

// ===== tb/srstc_partner.sv
// Stand-in for the fuse loader and the memory scanner beside the controller.
// Assumes the bench sets the fuse image and picks fast or slow answers.
`timescale 1ns/1ps
module srstc_partner
  import srstc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             fuse_load_req,
  input  wire logic             crc_scan_start,
  input  wire logic [SUT_W-1:0] cfg_sut,
  input  wire logic             cfg_crc,
  input  wire logic             slow,
  output logic                  fuse_load_done,
  output logic [SUT_W-1:0]      fuse_sut,
  output logic                  fuse_crc_at_boot,
  output logic                  fuse_reset_pin_en,
  output logic                  crc_scan_done
);
  logic [3:0] fcnt;
  logic [3:0] ccnt;

  always_ff @(posedge clk) begin
    if (!reset_n || !fuse_load_req) begin
      fcnt <= 4'h0;
    end else if (fcnt != 4'hF) begin
      fcnt <= fcnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !crc_scan_start) begin
      ccnt <= 4'h0;
    end else if (ccnt != 4'hF) begin
      ccnt <= ccnt + 4'h1;
    end
  end

  // fuse image reload
  // Off the done strobe the lines carry the inverse image, so late sampling shows.
  assign fuse_load_done    = fuse_load_req && fcnt == (slow ? 4'h6 : 4'h1);
  assign fuse_sut          = fuse_load_done ? cfg_sut : ~cfg_sut;
  assign fuse_crc_at_boot  = fuse_load_done ? cfg_crc : !cfg_crc;
  assign fuse_reset_pin_en = fuse_load_done;
  assign crc_scan_done     = crc_scan_start && ccnt == (slow ? 4'hA : 4'h2);
endmodule

// ===== tb/system_reset_controller_tb.sv
// Self-checking bench for the system reset controller.
// Assumes the partner model stands in for the fuse loader and the scanner.
`timescale 1ns/1ps
module system_reset_controller_tb
  import srstc_pkg::*;
;
  logic clk, reset_n, por_req, bod_req, pin_reset_n, wdt_req, dbg_req, cfg_crc, slow;
  logic fuse_load_req, fuse_load_done, fuse_crc_at_boot, fuse_reset_pin_en, crc_scan_start;
  logic crc_scan_done, sys_reset_n, rst_volatile_n, rst_tcd_override_n, rst_bod_cfg_n;
  logic rst_debug_n, tcd_override_avail, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [SUT_W-1:0]  cfg_sut, fuse_sut;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  int                errors, n_checks, init_cnt;

  srstc_top dut (.clk, .reset_n, .por_req, .bod_req, .pin_reset_n, .wdt_req, .dbg_req,
    .fuse_load_req, .fuse_load_done, .fuse_sut, .fuse_crc_at_boot, .fuse_reset_pin_en,
    .crc_scan_start, .crc_scan_done, .sys_reset_n, .rst_volatile_n, .rst_tcd_override_n,
    .rst_bod_cfg_n, .rst_debug_n, .tcd_override_avail, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  srstc_partner fl (.clk, .reset_n, .fuse_load_req, .crc_scan_start, .cfg_sut, .cfg_crc,
    .slow, .fuse_load_done, .fuse_sut, .fuse_crc_at_boot, .fuse_reset_pin_en, .crc_scan_done);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Length of the last initialisation, counted from the end of the fuse phase.
  always @(posedge clk) begin
    if (fuse_load_req) init_cnt <= 0;
    else if (!sys_reset_n) init_cnt <= init_cnt + 1;
  end

  task automatic final_report();
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, output logic [1:0] rs);
    logic aw, w, ta, tw;
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {3'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(negedge clk);
      ta = aw && s_axi_awready;
      tw = w && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw = aw && !ta;
      w = w && !tw;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [IDX_W-1:0] idx, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= {3'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [IDX_W-1:0] idx, input logic [31:0] mask,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  rs;
    axi_rd(idx, d, rs);
    check(name, exp, d & mask);
    check("rresp", 32'(RESP_OKAY), 32'(rs));
  endtask

  task automatic wait_run();
    do @(posedge clk); while (sys_reset_n !== 1'b1);
  endtask

  task automatic set_req(input int i, input logic v);
    case (i)
      0: wdt_req <= v;
      1: bod_req <= v;
      2: dbg_req <= v;
      default: pin_reset_n <= !v;
    endcase
  endtask

  task automatic t_por_boot();
    logic [1:0] rs;
    do @(negedge clk); while (fuse_load_req !== 1'b1);
    check("tcd_rst", 32'h0, 32'(rst_tcd_override_n));
    check("dbg_rst", 32'h0, 32'(rst_debug_n));
    wait_run();
    rd_chk("cause", IDX_CAUSE, 32'h3F, 32'(FLAGS_POR_ONLY));
    axi_wr(IDX_CAUSE, 8'h00, rs);
    rd_chk("cause", IDX_CAUSE, 32'h3F, 32'h01);
    axi_wr(IDX_CAUSE, 8'h01, rs);
    rd_chk("cause", IDX_CAUSE, 32'h3F, 32'h00);
  endtask

  task automatic t_sources();
    int fb[4] = '{FLAG_WDT, FLAG_BOD, FLAG_DBG, FLAG_PIN};
    logic [5:0] exp;
    int lo;
    exp = FLAGS_NONE;
    lo = INIT_CYCLES + 4 * SUT_UNIT_CYCLES + 10;
    cfg_sut <= 3'h3;
    cfg_crc <= 1'b1;
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      set_req(i, 1'b1);
      repeat (20) @(posedge clk);
      check("held", 32'h0, 32'(sys_reset_n));
      check("dbg_dom", 32'(i != 1), 32'(rst_debug_n));
      check("tcd_avail", 32'h1, 32'(tcd_override_avail));
      set_req(i, 1'b0);
      wait_run();
      exp[fb[i]] = 1'b1;
      rd_chk("cause", IDX_CAUSE, 32'h3F, 32'(exp));
      if (i == 0) begin
        check("init_len", 32'h1, 32'(init_cnt >= lo && init_cnt <= lo + 40));
        rd_chk("fuse_copy", IDX_STATUS, 32'h1F0, 32'h1B0);
        cfg_sut <= 3'h0;
        cfg_crc <= 1'b0;
        slow <= 1'b0;
      end
    end
  endtask

  task automatic t_power_on();
    logic [1:0] rs;
    @(posedge clk);
    por_req <= 1'b1;
    repeat (10) @(posedge clk);
    check("tcd_por", 32'h0, 32'(rst_tcd_override_n));
    por_req <= 1'b0;
    wait_run();
    rd_chk("cause", IDX_CAUSE, 32'h3F, 32'h01);
    axi_wr(IDX_CAUSE, 8'h3F, rs);
    rd_chk("cause", IDX_CAUSE, 32'h3F, 32'h00);
  endtask

  task automatic t_soft();
    logic [31:0] d;
    logic [1:0]  rs;
    axi_wr(IDX_SOFT_RST, 8'h01, rs);
    check("soft_resp", 32'(RESP_OKAY), 32'(rs));
    repeat (3) @(posedge clk);
    check("locked", 32'h1, 32'(sys_reset_n));
    // Three reads leave the write as the fourth access; four push it out.
    for (int n = 3; n <= 4; n++) begin
      axi_wr(IDX_UNLOCK, UNLOCK_KEY, rs);
      repeat (n) axi_rd(IDX_STATUS, d, rs);
      axi_wr(IDX_SOFT_RST, 8'h01, rs);
      repeat (3) @(posedge clk);
      check("sw_reset", 32'(n == 4), 32'(sys_reset_n));
      wait_run();
    end
    rd_chk("cause", IDX_CAUSE, 32'h3F, 32'h10);
    rd_chk("trigger", IDX_SOFT_RST, 32'h01, 32'h00);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  rs;
    axi_rd(3'h5, d, rs);
    check("rd_unmap", 32'(RESP_SLVERR), 32'(rs));
    axi_wr(3'h6, 8'hFF, rs);
    check("wr_unmap", 32'(RESP_SLVERR), 32'(rs));
    check("no_reset", 32'h1, 32'(sys_reset_n));
  endtask

  initial begin
    {reset_n, por_req, bod_req, wdt_req, dbg_req, cfg_crc, slow} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    pin_reset_n = 1'b1;
    cfg_sut = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    errors = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_por_boot();
    t_sources();
    t_power_on();
    t_soft();
    t_unmapped();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule
